// *** rtl/kmvs_scanner.sv ***
// What this block does
// - Status bit 7 flags pending key event
// - Data write to reported key clears flag
// - Status bits 6:0 give requesting key number
// - Status bits 9:8 give requesting key page
// - Key entry index is eight times column plus row
// - LED words drive columns during their row
// - Switch words hold return lines per row
// - ADC words hold analog level per row
// - Ten-bit conversion stored as eight bits
// - Rows 0..7 cycle, 5.2 us each at divide 1
// - Data port moves 11-bit word, upper ignored
// - Finished measurement sets request, clears busy
// - Entry bit 9 is key-on versus key-off
// - Entry bit 8 marks measurement in progress
// - Entry low byte holds velocity code
// - Interval scales with divider and matrix
// - Codes below 128 step one cycle
// - Upper codes double step per segment
// - Divider setting divides by 1, 2, 4
// - Matrix setting scans three to five rows
// - Key page follows upper row lines
// - Contact type and diode wiring bits
`timescale 1ns/1ps
`default_nettype none
`include "kmvs_consts.svh"

module kmvs_scanner
  import kmvs_pkg::*;
#(
  parameter int SLOT_CYC = `KMVS_ROW_SLOT_CYC // Cycles per row slot at divide 1
) (
  input wire logic clk_sys, // 40 MHz system clock
  input wire logic rst_b, // Async reset, active low
  input wire logic [3:0] io_addr, // I/O space address
  input wire logic io_wr, // I/O write strobe
  input wire logic io_rd, // I/O read strobe
  input wire logic [15:0] io_wdata, // I/O write data
  output logic [15:0] io_rdata, // I/O read data
  output logic [4:0] row_out, // Row select pins
  output logic [10:0] column_drive_lines, // Column drive pins
  input wire logic [10:0] return_sense_lines, // First contact and switch pins
  input wire logic [10:0] make_sense_lines, // Second contact pins
  input wire logic [9:0] analog_input_pin // Converter word from the slider input
);

  // ***************************************************
  // State and memories
  // ***************************************************
  kmvs_regs_type r_q; // Registered state
  kmvs_regs_type r_d; // Next state
  logic [10:0] key_ram [`KMVS_KEY_WORDS]; // Velocity and status entries
  logic [10:0] key_cnt [`KMVS_KEY_WORDS]; // Pressed bit and tick count
  logic [10:0] led_ram [8]; // LED words by row
  logic [10:0] sw_ram [16]; // Switch words by row
  logic [10:0] adc_ram [16]; // ADC words by row

  // Memory write controls
  logic kr_we; // Key entry write
  logic [8:0] kr_wa; // Key entry write address
  logic [10:0] kr_wd; // Key entry write data
  logic kc_we; // Key count write
  logic [10:0] kc_wd; // Key count write data
  logic led_we; // LED word write
  logic row_we; // Switch and ADC capture
  logic [3:0] row_idx; // Row[3:0] of the current slot

  // Column step helpers
  logic [8:0] step_idx; // Entry being scanned
  logic [10:0] step_e; // Its entry word
  logic [10:0] step_c; // Its count word
  logic [7:0] step_vel; // Code of its count
  logic cpu_key_we; // Processor writes a key entry
  logic [8:0] cpu_idx; // Processor key index
  logic [10:0] ram_word; // Word at the selected address
  logic [11:0] slot_len; // Slot length after divider
  logic [1:0] last_page; // Highest page for the matrix
  logic first_on; // First contact closed
  logic second_on; // Second contact closed
  logic pressed; // Key held down

  // Key index: eight entries per column, 88 per page
  function automatic logic [8:0] key_index(input logic [1:0] pg, input logic [6:0] a);
    key_index = {7'b0, pg} * `KMVS_KEYS_PER_PAGE + {2'b0, a};
  endfunction : key_index

  // ***************************************************
  // Velocity code of the key in the step
  // ***************************************************
  kmvs_vel_code u_vel (
    .tick_time(step_c[9:0]),
    .velocity_code(step_vel)
  );

  // ***************************************************
  // Derived values
  // ***************************************************
  // Unused divider and matrix codes act as their defaults
  always_comb begin
    // Divider stretches the slot; the sample point stays put
    case (r_q.cfg[`KMVS_CFG_DIV_HI:`KMVS_CFG_DIV_LO])
      2'd1: slot_len = 12'(SLOT_CYC * 2);
      2'd2: slot_len = 12'(SLOT_CYC * 4);
      default: slot_len = 12'(SLOT_CYC);
    endcase
    // Unused matrix code falls back to three rows
    if (r_q.cfg[`KMVS_CFG_MTX_HI:`KMVS_CFG_MTX_LO] == `KMVS_CFG_UNUSED) begin
      last_page = 2'd0;
    end else begin
      last_page = r_q.cfg[`KMVS_CFG_MTX_HI:`KMVS_CFG_MTX_LO];
    end
  end

  // Row[3:0] of this slot; row 3 is set on page 1
  assign row_idx = {r_q.page == 2'd1, r_q.row_lo};

  // Processor side address decode
  assign cpu_idx = key_index(r_q.ram_page, r_q.ram_addr);
  assign cpu_key_we = io_wr && (io_addr == `KMVS_IO_DATA) && (r_q.ram_addr <= `KMVS_KEY_LAST)
                      && (r_q.ram_page != `KMVS_UNUSED_PAGE);

  // Word at the selected address, page ignored above the keys
  always_comb begin
    if (r_q.ram_addr <= `KMVS_KEY_LAST) begin
      ram_word = (r_q.ram_page == `KMVS_UNUSED_PAGE) ? 11'h000 : key_ram[cpu_idx];
    end else if (r_q.ram_addr < `KMVS_SW_BASE) begin
      ram_word = led_ram[r_q.ram_addr[2:0]];
    end else if (r_q.ram_addr < `KMVS_ADC_BASE) begin
      ram_word = sw_ram[r_q.ram_addr[3:0]];
    end else begin
      ram_word = adc_ram[r_q.ram_addr[3:0]];
    end
  end

  // Contacts of the key in the step; polarity from the wiring bits
  assign step_idx = key_index(r_q.page, {r_q.col[3:0], r_q.row_lo});
  assign step_e = key_ram[step_idx];
  assign step_c = key_cnt[step_idx];
  assign first_on = r_q.first_c[r_q.col] ^ r_q.cfg[`KMVS_CFG_CATHODE] ^ r_q.cfg[`KMVS_CFG_SPRING];
  assign second_on = r_q.second_c[r_q.col] ^ r_q.cfg[`KMVS_CFG_CATHODE];
  assign pressed = step_c[`KMVS_C_PRESSED];

  // ***************************************************
  // Next state
  // ***************************************************
  always_comb begin
    r_d = r_q;
    kr_we = 1'b0;
    kr_wa = step_idx;
    kr_wd = step_e;
    kc_we = 1'b0;
    kc_wd = step_c;
    led_we = 1'b0;
    row_we = 1'b0;

    // Pin synchronisers: first stage feeds only the second
    r_d.ret_s1 = return_sense_lines;
    r_d.ret_s2 = r_q.ret_s1;
    r_d.mk_s1 = make_sense_lines;
    r_d.mk_s2 = r_q.mk_s1;
    r_d.adc_s1 = analog_input_pin;
    r_d.adc_s2 = r_q.adc_s1;

    // Processor writes
    if (io_wr) begin
      case (io_addr)
        `KMVS_IO_CFG: begin
          // Write only; reads of this offset give zero
          r_d.cfg = io_wdata[5:0];
        end
        `KMVS_IO_STAT: begin
          // Bit 7 of the address word is dropped
          r_d.ram_addr = io_wdata[6:0];
          r_d.ram_page = io_wdata[9:8];
        end
        `KMVS_IO_DATA: begin
          // Page 3 keys and switch or ADC words are refused
          if (cpu_key_we) begin
            kr_we = 1'b1;
            kr_wa = cpu_idx;
            kr_wd = io_wdata[10:0];
            // Only the reported entry clears the flag
            if (r_q.key_request_flag && cpu_idx == key_index(r_q.rep_page, r_q.rep_key)) begin
              r_d.key_request_flag = 1'b0;
            end
          end else if (r_q.ram_addr >= `KMVS_LED_BASE && r_q.ram_addr < `KMVS_SW_BASE) begin
            led_we = 1'b1;
          end
        end
        default: begin
          // Other offsets belong elsewhere
        end
      endcase
    end

    // Processor reads, registered one cycle later
    if (io_rd) begin
      case (io_addr)
        `KMVS_IO_STAT: r_d.rdata = {6'h00, r_q.rep_page, r_q.key_request_flag, r_q.rep_key};
        `KMVS_IO_DATA: r_d.rdata = {5'h00, ram_word};
        default: r_d.rdata = 16'h0000;
      endcase
    end

    // Search for the next pending key only while none is shown;
    // so a new report never meets a clear in the same cycle
    if (!r_q.key_request_flag) begin
      if (key_ram[key_index(r_q.srch_page, r_q.srch_idx)][`KMVS_E_SRQ]) begin
        r_d.key_request_flag = 1'b1;
        r_d.rep_key = r_q.srch_idx;
        r_d.rep_page = r_q.srch_page;
      end
      // Walk wraps over pages 0 to 2, one entry a cycle
      if (r_q.srch_idx == `KMVS_KEY_LAST) begin
        r_d.srch_idx = 7'h00;
        r_d.srch_page = (r_q.srch_page == `KMVS_LAST_PAGE) ? 2'd0 : r_q.srch_page + 2'd1;
      end else begin
        r_d.srch_idx = r_q.srch_idx + 7'h01;
      end
    end

    // Row slot timing
    if (r_q.slot_cnt >= slot_len - 12'd1) begin
      r_d.slot_cnt = 12'h000;
      r_d.row_lo = r_q.row_lo + 3'd1;
      // Page steps once per full row cycle
      if (r_q.row_lo == `KMVS_LAST_ROW) begin
        r_d.page = (r_q.page >= last_page) ? 2'd0 : r_q.page + 2'd1;
      end
      // Columns change with the row, at the same edge
      r_d.drive = led_ram[r_d.row_lo];
    end else begin
      r_d.slot_cnt = r_q.slot_cnt + 12'h001;
    end

    case (r_q.st)
      KMVS_ST_WAIT: begin
        // Cycle 104, mid slot at divide 1 only: lines have settled, capture them
        if (r_q.slot_cnt == `KMVS_SAMPLE_AT) begin
          r_d.first_c = r_q.ret_s2;
          r_d.second_c = r_q.mk_s2;
          row_we = 1'b1;
          r_d.col = 4'd0;
          r_d.st = KMVS_ST_COLS;
        end
      end
      KMVS_ST_COLS: begin
        // Processor key writes take the port; the walk waits a cycle
        if (!cpu_key_we) begin
          kr_we = 1'b1;
          kc_we = 1'b1;
          // Idle key: the leading contact starts a measurement
          if (!step_e[`KMVS_E_BUSY]) begin
            if (pressed ? !second_on : first_on) begin
              kr_wd[`KMVS_E_BUSY] = 1'b1;
              kc_wd[9:0] = 10'h000;
            end
          end else if (pressed ? !first_on : second_on) begin
            // Trailing contact reached: post the result
            kr_wd = {1'b1, !pressed, 1'b0, step_vel};
            kc_wd = {!pressed, 10'h000};
          end else if (pressed ? second_on : !first_on) begin
            kr_wd[`KMVS_E_BUSY] = 1'b0; // Contact bounced back
          end else if (step_c[9:0] < `KMVS_TICK_MAX) begin
            kc_wd[9:0] = step_c[9:0] + 10'h001; // one tick per visit
          end
          // Eleven columns a slot, then wait for the next
          if (r_q.col == `KMVS_LAST_COL) begin
            r_d.st = KMVS_ST_WAIT;
          end else begin
            r_d.col = r_q.col + 4'd1;
          end
        end
      end
      default: begin
        // Illegal code recovers to waiting
        r_d.st = KMVS_ST_WAIT;
      end
    endcase
  end

  // ***************************************************
  // State register
  // ***************************************************
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      r_q <= '{st: KMVS_ST_WAIT, cfg: `KMVS_CFG_RST, default: '0};
    end else begin
      // Whole state moves in one register
      r_q <= r_d;
    end
  end

  // ***************************************************
  // Scanning RAM
  // ***************************************************
  // Reset so no stale request is reported after power-up
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `KMVS_KEY_WORDS; i++) begin
        key_ram[i] <= 11'h000;
        key_cnt[i] <= 11'h000;
      end
      for (int j = 0; j < 16; j++) begin
        sw_ram[j] <= 11'h000;
        adc_ram[j] <= 11'h000;
      end
      for (int k = 0; k < 8; k++) begin
        led_ram[k] <= 11'h000;
      end
    end else begin
      // One entry port, shared by the processor and the walk
      if (kr_we) begin
        key_ram[kr_wa] <= kr_wd;
      end
      if (kc_we) begin
        key_cnt[step_idx] <= kc_wd;
      end
      // LED words ignore the key page
      if (led_we) begin
        led_ram[r_q.ram_addr[2:0]] <= io_wdata[10:0];
      end
      // Switch and converter words share one sample point
      if (row_we) begin
        sw_ram[row_idx] <= r_q.ret_s2;
        adc_ram[row_idx] <= {3'b000, r_q.adc_s2[9:2]};
      end
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  // Outputs decode registered state only
  assign io_rdata = r_q.rdata;
  assign row_out = {r_q.page == 2'd2, r_q.page == 2'd1, r_q.row_lo};
  assign column_drive_lines = r_q.drive;

endmodule : kmvs_scanner
`default_nettype wire

// *** rtl/kmvs_consts.svh ***
`ifndef KMVS_CONSTS_SVH
`define KMVS_CONSTS_SVH

// ***************************************************
// I/O space offsets
// ***************************************************
`define KMVS_IO_CFG 4'hb
`define KMVS_IO_STAT 4'hc
`define KMVS_IO_DATA 4'hd

// ***************************************************
// Scanning RAM map
// ***************************************************
`define KMVS_KEY_LAST 7'h57
`define KMVS_LED_BASE 7'h58
`define KMVS_SW_BASE 7'h60
`define KMVS_ADC_BASE 7'h70
`define KMVS_KEYS_PER_PAGE 9'd88
`define KMVS_KEY_WORDS 264
`define KMVS_LAST_COL 4'd10
`define KMVS_LAST_ROW 3'd7
`define KMVS_LAST_PAGE 2'd2
`define KMVS_UNUSED_PAGE 2'd3

// ***************************************************
// Key entry and status fields
// ***************************************************
`define KMVS_E_SRQ 10
`define KMVS_E_ON 9
`define KMVS_E_BUSY 8
`define KMVS_C_PRESSED 10

// ***************************************************
// Configuration fields and reset value
// ***************************************************
`define KMVS_CFG_RST 6'h00
`define KMVS_CFG_SPRING 0
`define KMVS_CFG_CATHODE 1
`define KMVS_CFG_DIV_HI 3
`define KMVS_CFG_DIV_LO 2
`define KMVS_CFG_MTX_HI 5
`define KMVS_CFG_MTX_LO 4
`define KMVS_CFG_UNUSED 2'd3

// ***************************************************
// Timing
// ***************************************************
`define KMVS_CLK_PERIOD_NS 25
`define KMVS_ROW_SLOT_NS 5200
`define KMVS_ROW_SLOT_CYC ((`KMVS_ROW_SLOT_NS + `KMVS_CLK_PERIOD_NS - 1) / `KMVS_CLK_PERIOD_NS)
`define KMVS_SAMPLE_AT 12'd104

// ***************************************************
// Velocity curve segment starts, in ticks and in codes
// ***************************************************
`define KMVS_SEG1 10'd128
`define KMVS_SEG2 10'd256
`define KMVS_SEG3 10'd384
`define KMVS_SEG4 10'd512
`define KMVS_TICK_MAX 10'd768
`define KMVS_VEL_SEG1 8'd128
`define KMVS_VEL_SEG2 8'd192
`define KMVS_VEL_SEG3 8'd224
`define KMVS_VEL_SEG4 8'd240

`endif

// *** rtl/kmvs_pkg.sv ***
package kmvs_pkg;

  // Slot phase: waiting in the row slot, or walking the columns
  typedef enum logic [1:0] {
    KMVS_ST_WAIT = 2'b01,
    KMVS_ST_COLS = 2'b10
  } kmvs_state_type;

  // All control state of the scanner
  typedef struct packed {
    kmvs_state_type st;
    logic [11:0] slot_cnt;
    logic [2:0] row_lo;
    logic [1:0] page;
    logic [3:0] col;
    logic [5:0] cfg;
    logic [1:0] ram_page;
    logic [6:0] ram_addr;
    logic key_request_flag;
    logic [6:0] rep_key;
    logic [1:0] rep_page;
    logic [6:0] srch_idx;
    logic [1:0] srch_page;
    logic [15:0] rdata;
    logic [10:0] drive;
    logic [10:0] ret_s1;
    logic [10:0] ret_s2;
    logic [10:0] mk_s1;
    logic [10:0] mk_s2;
    logic [9:0] adc_s1;
    logic [9:0] adc_s2;
    logic [10:0] first_c;
    logic [10:0] second_c;
  } kmvs_regs_type;

endpackage : kmvs_pkg

// *** rtl/kmvs_vel_code.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "kmvs_consts.svh"

module kmvs_vel_code
  import kmvs_pkg::*;
(
  input wire logic [9:0] tick_time, // Row cycles between contacts
  output logic [7:0] velocity_code // Log-scale code
);

  logic [9:0] rel; // Ticks past the segment start

  // ***************************************************
  // Piecewise linear log curve
  // ***************************************************
  // Step doubles at each segment; saturates at the top code
  always_comb begin
    rel = 10'd0;
    if (tick_time < `KMVS_SEG1) begin
      velocity_code = tick_time[7:0];
    end else if (tick_time < `KMVS_SEG2) begin
      rel = tick_time - `KMVS_SEG1;
      velocity_code = `KMVS_VEL_SEG1 + rel[8:1];
    end else if (tick_time < `KMVS_SEG3) begin
      rel = tick_time - `KMVS_SEG2;
      velocity_code = `KMVS_VEL_SEG2 + {2'b0, rel[7:2]};
    end else if (tick_time < `KMVS_SEG4) begin
      rel = tick_time - `KMVS_SEG3;
      velocity_code = `KMVS_VEL_SEG3 + {3'b0, rel[7:3]};
    end else if (tick_time < `KMVS_TICK_MAX) begin
      rel = tick_time - `KMVS_SEG4;
      velocity_code = `KMVS_VEL_SEG4 + {4'b0, rel[7:4]};
    end else begin
      velocity_code = 8'hff; // Longest interval
    end
  end

endmodule : kmvs_vel_code
`default_nettype wire

// *** testbench/kmvs_scanner_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checks for the scanner
// ****
module kmvs_scanner_properties
  import kmvs_pkg::*;
#(
  parameter int SLOT_CYC = 208 // Row slot at divide 1
) (
  input wire logic clk_sys, // Clock
  input wire logic rst_b, // Reset, active low
  input wire logic [3:0] io_addr, // I/O offset
  input wire logic io_wr, // Write strobe
  input wire logic io_rd, // Read strobe
  input wire logic [15:0] io_wdata, // Write data
  input wire logic [15:0] io_rdata, // Read data
  input wire logic [4:0] row_out, // Row and page lines
  input wire logic [10:0] column_drive_lines // LED columns
);
  // Shadow of processor writes and of row slot timing
  typedef struct packed {
    logic [5:0] cfg; // Last configuration
    logic [9:0] ptr; // Address port
    logic [2:0] rowp; // Row seen last cycle
    logic [12:0] cnt; // Cycles since row change
    logic [3:0] settle; // Row changes since cfg write
    logic [87:0] led; // LED words
    logic [10:0] snap; // LED word at row change
  } kmvs_chk_type;
  kmvs_chk_type h_q;
  kmvs_chk_type h_d;

  // Next shadow; a new cfg needs fifteen row changes before the page is trusted
  always_comb begin
    h_d = h_q;
    h_d.rowp = row_out[2:0];
    h_d.cnt = h_q.cnt + 13'h1;
    if (row_out[2:0] != h_q.rowp) begin
      h_d.cnt = 13'h0;
      h_d.snap = h_q.led[row_out[2:0]*11 +: 11];
      if (h_q.settle != 4'hf) h_d.settle = h_q.settle + 4'h1;
    end
    if (io_wr && io_addr == 4'hb) begin
      h_d.cfg = io_wdata[5:0];
      h_d.settle = 4'h0;
    end
    if (io_wr && io_addr == 4'hc) h_d.ptr = io_wdata[9:0];
    if (io_wr && io_addr == 4'hd && h_q.ptr[6:3] == 4'hb) h_d.led[h_q.ptr[2:0]*11 +: 11] = io_wdata[10:0];
  end

  // Shadow register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) h_q <= '0;
    else h_q <= h_d;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_row_step: assert property ($changed(row_out[2:0]) |-> row_out[2:0] == $past(row_out[2:0]) + 3'h1)
    else $error("Row lines stepped out of order");
  a_slot_len: assert property ($changed(row_out[2:0]) && h_q.settle == 4'hf && h_q.cfg[3:2] != 2'h3
    |-> h_q.cnt == 13'((SLOT_CYC << h_q.cfg[3:2]) - 1))
    else $error("Row slot has the wrong length");
  a_page_form: assert property (h_q.settle == 4'hf |-> row_out[4:3] != 2'h3
    && (h_q.cfg[5:4] != 2'h0 || row_out[4:3] == 2'h0) && (h_q.cfg[5:4] != 2'h1 || !row_out[4]))
    else $error("Page lines disagree with the matrix setting");
  a_led_drive: assert property ($changed(row_out[2:0]) && !io_wr && !$past(io_wr)
    |-> ##2 column_drive_lines == h_q.snap)
    else $error("Columns do not show the LED word of the row");
  a_led_read: assert property (io_rd && io_addr == 4'hd && h_q.ptr[6:3] == 4'hb
    |=> io_rdata[10:0] == h_q.led[h_q.ptr[2:0]*11 +: 11])
    else $error("LED word read back wrong");
  a_status_form: assert property (io_rd && io_addr == 4'hc |=> io_rdata[15:10] == 6'h0
    && io_rdata[9:8] != 2'h3 && (!io_rdata[7] || io_rdata[6:0] <= 7'h57))
    else $error("Status word out of range");
  a_page3_zero: assert property (io_rd && io_addr == 4'hd && h_q.ptr[9:8] == 2'h3
    && h_q.ptr[6:0] <= 7'h57 |=> io_rdata == 16'h0)
    else $error("Unused key page read not zero");
  a_odd_offset: assert property (io_rd && io_addr != 4'hc && io_addr != 4'hd |=> io_rdata == 16'h0)
    else $error("Unmapped offset read not zero");
  a_rdata_hold: assert property (!io_rd |=> $stable(io_rdata))
    else $error("Read data moved without a read");
endmodule : kmvs_scanner_properties

bind kmvs_scanner kmvs_scanner_properties #(.SLOT_CYC(SLOT_CYC)) u_props (
  .clk_sys(clk_sys), .rst_b(rst_b), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
  .io_wdata(io_wdata), .io_rdata(io_rdata), .row_out(row_out), .column_drive_lines(column_drive_lines)
);
`default_nettype wire

// *** testbench/kmvs_matrix_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Key matrix, switches and slider
// ****
module kmvs_matrix_model
  import kmvs_pkg::*;
(
  input wire logic [4:0] row_out, // Row and page lines
  input wire logic [263:0] first_closed, // First contact per key
  input wire logic [263:0] second_closed, // Second contact per key
  input wire logic [10:0] switch_mask, // Switch pattern, zero when idle
  input wire logic [6:0] adc_low, // Slider low bits
  output logic [10:0] return_sense_lines, // First contacts and switches
  output logic [10:0] make_sense_lines, // Second contacts
  output logic [9:0] analog_input_pin // Converter word
);
  logic [1:0] page; // Page of the selected rows
  int idx; // Key number of a crossing

  // Contacts of the selected row; row mixed into switches and slider so words differ
  always_comb begin
    page = row_out[4] ? 2'h2 : {1'b0, row_out[3]};
    for (int c = 0; c < 11; c++) begin
      idx = page * 88 + c * 8 + row_out[2:0];
      return_sense_lines[c] = first_closed[idx];
      make_sense_lines[c] = second_closed[idx];
    end
    if (switch_mask != 11'h0) return_sense_lines = return_sense_lines | (switch_mask ^ {8'h0, row_out[2:0]});
    analog_input_pin = {row_out[2:0], adc_low};
  end
endmodule : kmvs_matrix_model
`default_nettype wire

// *** testbench/kmvs_scanner_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module kmvs_scanner_test import kmvs_pkg::*;;
  localparam int SLOT = 208; // Row slot at divide 1
  localparam int CYC8 = SLOT * 8; // One row cycle
  localparam int KEY_A = 42; // Column 5, row 2
  localparam int KEY_B = 87; // Last key
  typedef struct packed {
    logic [9:0] wa; // Address port for the write
    logic [15:0] wd; // Data written
    logic [9:0] ra; // Address port for the read
    logic [10:0] ex; // Word expected back
  } kmvs_row_type;
  kmvs_row_type tbl [0:9] = '{'{10'h058, 16'hf801, 10'h258, 11'h001}, '{10'h159, 16'h0400, 10'h059, 11'h400},
    '{10'h0da, 16'h00f0, 10'h05a, 11'h0f0}, '{10'h05b, 16'h000f, 10'h05b, 11'h00f},
    '{10'h25c, 16'h0555, 10'h05c, 11'h555}, '{10'h05d, 16'h02aa, 10'h05d, 11'h2aa},
    '{10'h05e, 16'h0333, 10'h05e, 11'h333}, '{10'h35f, 16'h07ff, 10'h05f, 11'h7ff},
    '{10'h30a, 16'h0123, 10'h30a, 11'h000}, '{10'h065, 16'h07ff, 10'h065, 11'h000}};
  logic clk_sys, rst_b, io_wr, io_rd;
  logic [3:0] io_addr;
  logic [15:0] io_wdata, io_rdata;
  logic [4:0] row_out;
  logic [10:0] column_drive_lines, return_sense_lines, make_sense_lines, sw;
  logic [9:0] analog_input_pin;
  logic [263:0] fc, sc;
  logic [6:0] al;
  logic [10:0] led_exp [8];
  int mismatches, compares;

  kmvs_scanner #(.SLOT_CYC(SLOT)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .row_out(row_out),
    .column_drive_lines(column_drive_lines), .return_sense_lines(return_sense_lines),
    .make_sense_lines(make_sense_lines), .analog_input_pin(analog_input_pin));
  kmvs_matrix_model u_model (.row_out(row_out), .first_closed(fc), .second_closed(sc), .switch_mask(sw),
    .adc_low(al), .return_sense_lines(return_sense_lines), .make_sense_lines(make_sense_lines),
    .analog_input_pin(analog_input_pin));

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop;
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // A wait that ran out ends the run
  task automatic give_up(input string what);
    mismatches++;
    $display("[ERR] %s expected done seen timeout", what);
    report_and_stop();
  endtask : give_up

  // Every task starts and ends just after a rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    cyc(1);
    io_wr = 1'b0;
    cyc(1);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    io_addr = a;
    io_rd = 1'b1;
    cyc(1);
    io_rd = 1'b0;
    cyc(1);
    v = io_rdata;
  endtask : rd

  // Cycles until the row lines move
  task automatic next_row(output int n);
    logic [2:0] r;
    r = row_out[2:0];
    n = 0;
    while (row_out[2:0] === r) begin
      cyc(1);
      n++;
      if (n > 4000) give_up("row change");
    end
  endtask : next_row

  task automatic poll(output logic [15:0] s);
    for (int k = 0; k < 3000; k++) begin
      rd(4'hc, s);
      if (s[7] === 1'b1) return;
    end
    give_up("key flag");
  endtask : poll

  // Serve both pending keys; order is the design's, both must come
  task automatic serve(input logic on, input int n);
    logic [15:0] s;
    logic [15:0] e;
    logic [1:0] seen;
    seen = 2'h0;
    repeat (2) begin
      poll(s);
      check("page", {14'h0, s[9:8]}, 16'h0);
      check("key", {15'h0, s[6:0] == 7'h2a || s[6:0] == 7'h57}, 16'h1);
      seen = seen | {s[6:0] == 7'h57, s[6:0] == 7'h2a};
      wr(4'hc, {6'h0, s[9:0]});
      rd(4'hd, e);
      check("entry", {13'h0, e[10:8]}, {13'h0, 1'b1, on, 1'b0});
      check("vel", {15'h0, e[7:0] + 8'h1 >= n[7:0] && e[7:0] <= n[7:0] + 8'h1}, 16'h1);
      wr(4'hd, 16'h0);
      rd(4'hc, e);
      check("cleared", {15'h0, e[7] === 1'b0 || e[6:0] !== s[6:0]}, 16'h1);
    end
    check("both", {14'h0, seen}, 16'h3);
  endtask : serve

  // Main sequence
  initial begin
    logic [15:0] v;
    int n;
    logic [3:0] pg;
    mismatches = 0;
    compares = 0;
    rst_b = 1'b0;
    {io_addr, io_wr, io_rd, io_wdata, fc, sc, sw} = '0;
    al = 7'h4b;
    led_exp = '{default: 11'h0};
    cyc(4);
    rst_b = 1'b1;
    check("row", {11'h0, row_out}, 16'h0);
    rd(4'hc, v);
    check("status", v, 16'h0);
    rd(4'hb, v);
    check("cfg read", v, 16'h0);
    foreach (tbl[i]) begin
      wr(4'hc, {6'h0, tbl[i].wa});
      wr(4'hd, tbl[i].wd);
      wr(4'hc, {6'h0, tbl[i].ra});
      rd(4'hd, v);
      check("ram", {5'h0, v[10:0]}, {5'h0, tbl[i].ex});
      if (tbl[i].ra[6:3] == 4'hb) led_exp[tbl[i].ra[2:0]] = tbl[i].ex;
    end
    repeat (9) begin
      next_row(n);
      cyc(3);
      check("columns", {5'h0, column_drive_lines}, {5'h0, led_exp[row_out[2:0]]});
    end
    sw = 11'h5a0;
    cyc(2 * CYC8);
    for (int r = 0; r < 16; r++) begin
      wr(4'hc, 16'h60 + r[15:0]);
      rd(4'hd, v);
      check("switch", {5'h0, v[10:0]}, r < 8 ? {5'h0, 11'h5a0 ^ r[10:0]} : 16'h0);
      wr(4'hc, 16'h70 + r[15:0]);
      rd(4'hd, v);
      check("adc", {8'h0, v[7:0]}, r < 8 ? {8'h0, r[2:0], al[6:2]} : 16'h0);
    end
    sw = 11'h0;
    // Switches held keys busy; let every key see its contact open first
    cyc(CYC8 + 4);
    fc[KEY_A] = 1'b1;
    fc[KEY_B] = 1'b1;
    cyc(2 * CYC8);
    wr(4'hc, 16'h002a);
    rd(4'hd, v);
    check("busy", {14'h0, v[10], v[8]}, 16'h1);
    cyc(4 * CYC8);
    sc[KEY_A] = 1'b1;
    sc[KEY_B] = 1'b1;
    serve(1'b1, 6);
    sc = '0;
    cyc(3 * CYC8);
    fc = '0;
    serve(1'b0, 3);
    wr(4'hb, 16'h0001);
    cyc(CYC8 + 8);
    wr(4'hc, 16'h002a);
    rd(4'hd, v);
    check("spring", {14'h0, v[10], v[8]}, 16'h1);
    for (int m = 0; m < 3; m++) begin
      wr(4'hb, {10'h0, m[1:0], m[1:0], 2'h0});
      pg = 4'h0;
      for (int k = 0; k < 8 * (m + 1) + 2; k++) begin
        next_row(n);
        pg[row_out[4:3]] = 1'b1;
      end
      check("slot", n[15:0], 16'(SLOT << m));
      check("pages", {12'h0, pg}, m == 0 ? 16'h1 : (m == 1 ? 16'h3 : 16'h7));
    end
    rst_b = 1'b0;
    cyc(4);
    rst_b = 1'b1;
    check("row", {11'h0, row_out}, 16'h0);
    next_row(n);
    next_row(n);
    check("slot", n[15:0], 16'(SLOT));
    report_and_stop();
  end
endmodule : kmvs_scanner_test
`default_nettype wire
